// ### src/capc_pkg.sv
// Constants for the counter array 16-bit PWM control block
package capc_pkg;
    // ========================================================
    // Register addresses and pages
    localparam logic [7:0] ADDR_CTRL     = 8'hD8;
    localparam logic [7:0] ADDR_MODE     = 8'hED;
    localparam logic [7:0] ADDR_CPM_BASE = 8'hDA;
    localparam logic [7:0] ADDR_CPL_BASE = 8'hF1;
    localparam logic [7:0] ADDR_CPH_BASE = 8'hF2;
    localparam logic [7:0] ADDR_CP_STEP  = 8'h02;
    localparam logic [3:0] PAGE_F        = 4'hF;
    // ========================================================
    // Field positions and masks
    localparam int         CTRL_OVF    = 7;
    localparam int         CTRL_RUN    = 6;
    localparam logic [7:0] CTRL_MASK   = 8'hC7;
    localparam int         MODE_IDLE   = 7;
    localparam int         MODE_TB     = 1;
    localparam int         MODE_OVF_IE = 0;
    localparam logic [7:0] MODE_MASK = 8'h8F;
    localparam int         CPM_WIDE  = 7;
    localparam int         CPM_ECOM  = 6;
    localparam int         CPM_MAT   = 3;
    localparam int         CPM_PWM   = 1;
    localparam int         CPM_ECCF  = 0;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // ========================================================
    // Timebase codes and dividers
    localparam logic [2:0] TB_DIV12  = 3'h0;
    localparam logic [2:0] TB_DIV4   = 3'h1;
    localparam logic [2:0] TB_TIMER0 = 3'h2;
    localparam logic [2:0] TB_EXTIN  = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_EXTOSC = 3'h5;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [1:0] DIV4_ZERO  = 2'h0;
    localparam logic [2:0] DIV8_LAST  = 3'h7;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
endpackage

// ### src/capc_channel.sv
// One capture/compare module in 16-bit PWM mode
`timescale 1ns/1ns
`default_nettype none
module capc_channel
    import capc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Counter view
    input  wire logic [15:0] count,
    input  wire logic        advanced,
    input  wire logic        wrapped,
    // Module setup
    input  wire logic [15:0] compare_value,
    input  wire logic [7:0]  mode,
    // Results
    output logic             pin_r,
    output logic             match
);
    logic wide_sel;
    logic pin_nxt;

    // Shared cycle length is not an input here at all
    assign wide_sel = mode[CPM_ECOM] & mode[CPM_PWM]
                    & mode[CPM_WIDE];
    assign match    = advanced & mode[CPM_ECOM]
                    & (count == compare_value);

    // Match beats wrap so a zero compare stays high
    always_comb begin
        pin_nxt = pin_r;
        if (!wide_sel) begin
            pin_nxt = 1'b0;
        end else if (match) begin
            pin_nxt = 1'b1;
        end else if (wrapped) begin
            pin_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    a_pin_disabled: assert property (@(posedge clk) disable iff (rst)
        !mode[CPM_ECOM] |=> !pin_r)
        else $error("pin high with compare disabled");
endmodule
`default_nettype wire

// ### src/capc_top.sv
// Counter array control with 16-bit PWM modules on the register port
`timescale 1ns/1ns
`default_nettype none
module capc_top
    import capc_pkg::*;
#(
    parameter int NUM_MODULES = 3
)(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Special function register port
    input  wire logic [7:0]             sfr_addr,
    input  wire logic [3:0]             sfr_page,
    input  wire logic                   sfr_wr_en,
    input  wire logic [7:0]             sfr_wdata,
    output logic      [7:0]             sfr_rdata_r,
    // Bit-addressed access to the control register
    input  wire logic                   bit_wr_en,
    input  wire logic [2:0]             bit_index,
    input  wire logic                   bit_value,
    // System context
    input  wire logic                   cpu_idle,
    input  wire logic                   timer0_overflow,
    input  wire logic                   external_count_input,
    input  wire logic                   external_osc_clk,
    // Outputs
    output logic [NUM_MODULES-1:0]      module_output_pin,
    output logic                        irq_r
);
    // ========================================================
    // Elaboration check
    if (NUM_MODULES < 1 || NUM_MODULES > 3) begin : g_bad_count
        $error("NUM_MODULES must be 1 to 3");
    end

    // ========================================================
    // Decoding helpers
    function automatic logic mod_hit(input logic [7:0] addr,
                                     input logic [7:0] base,
                                     input int         idx);
        logic [7:0] offs;
        offs    = 8'(idx) * ADDR_CP_STEP;
        mod_hit = (addr == 8'(base + offs));
    endfunction

    function automatic logic cpm_hit(input logic [7:0] addr,
                                     input int         idx);
        cpm_hit = (addr == 8'(ADDR_CPM_BASE + 8'(idx)));
    endfunction

    // ========================================================
    // Register state
    logic        ovf_r;
    logic        run_r;
    logic [NUM_MODULES-1:0] ccf_r;
    logic [7:0]  mode_r;
    logic [7:0]  cpm_r [NUM_MODULES];
    logic [15:0] cmp_r [NUM_MODULES];
    logic [15:0] count_r;
    logic        adv_r;
    logic        wrap_r;
    logic [NUM_MODULES-1:0] match;
    logic [7:0]  ctrl_view;

    logic page_f;
    logic wr_ctrl;
    logic wr_mode;
    assign page_f  = (sfr_page == PAGE_F);
    assign wr_ctrl = sfr_wr_en & (sfr_addr == ADDR_CTRL);
    assign wr_mode = sfr_wr_en & page_f & (sfr_addr == ADDR_MODE);

    // ========================================================
    // Timebase sources
    logic [3:0] div12_r;
    logic       ext_s1_r;
    logic       ext_s2_r;
    logic       ext_s3_r;
    logic       osc_s1_r;
    logic       osc_s2_r;
    logic       osc_s3_r;
    logic [2:0] osc_div_r;
    logic       osc_tick;
    logic       ext_fall;
    logic       tick;
    logic       run_en;
    logic [2:0] tb_sel;

    assign tb_sel = mode_r[MODE_TB +: 3];

    always_ff @(posedge clk) begin
        if (rst) begin
            div12_r <= 4'h0;
        end else if (div12_r == DIV12_LAST) begin
            div12_r <= 4'h0;
        end else begin
            div12_r <= div12_r + 4'h1;
        end
    end

    // Two flops before any edge logic looks at the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= external_count_input;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            osc_s1_r <= external_osc_clk;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // Sampling needs the input at most a quarter of clk
    assign ext_fall = ext_s3_r & ~ext_s2_r;

    // Oscillator below half of clk divided by eight
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_div_r <= 3'h0;
        end else if (osc_s2_r & ~osc_s3_r) begin
            osc_div_r <= osc_div_r + 3'h1;
        end
    end
    assign osc_tick = osc_s2_r & ~osc_s3_r
                    & (osc_div_r == DIV8_LAST);

    // Reserved codes give no tick
    always_comb begin
        tick = 1'b0;
        case (tb_sel)
            TB_DIV12:  tick = (div12_r == 4'h0);
            TB_DIV4:   tick = (div12_r[1:0] == DIV4_ZERO);
            TB_TIMER0: tick = timer0_overflow;
            TB_EXTIN:  tick = ext_fall;
            TB_SYSCLK: tick = 1'b1;
            TB_EXTOSC: tick = osc_tick;
            default:   tick = 1'b0;
        endcase
    end

    assign run_en = run_r
                  & ~(mode_r[MODE_IDLE] & cpu_idle);

    // ========================================================
    // Counter
    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= 16'h0000;
            adv_r   <= 1'b0;
            wrap_r  <= 1'b0;
        end else begin
            adv_r  <= tick & run_en;
            wrap_r <= tick & run_en & (count_r == CNT_MAX);
            if (tick & run_en) begin
                count_r <= count_r + CNT_ONE;
            end
        end
    end

    // ========================================================
    // Control register: hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ovf_r <= sfr_wdata[CTRL_OVF];
                run_r <= sfr_wdata[CTRL_RUN];
            end else if (bit_wr_en) begin
                if (bit_index == 3'(CTRL_OVF)) begin
                    ovf_r <= bit_value;
                end
                if (bit_index == 3'(CTRL_RUN)) begin
                    run_r <= bit_value;
                end
            end
            if (tick & run_en & (count_r == CNT_MAX)) begin
                ovf_r <= 1'b1;
            end
        end
    end

    // Module event flags, same priority as the overflow flag
    always_ff @(posedge clk) begin
        if (rst) begin
            ccf_r <= '0;
        end else begin
            for (int n = 0; n < NUM_MODULES; n++) begin
                if (wr_ctrl) begin
                    ccf_r[n] <= sfr_wdata[n];
                end else if (bit_wr_en && bit_index == 3'(n)) begin
                    ccf_r[n] <= bit_value;
                end
                if (match[n] & cpm_r[n][CPM_MAT]) begin
                    ccf_r[n] <= 1'b1;
                end
            end
        end
    end

    // ========================================================
    // Mode register: unused bits never stored
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= RESET_VAL;
        end else if (wr_mode) begin
            mode_r <= sfr_wdata & MODE_MASK;
        end
    end

    // ========================================================
    // Module mode and compare registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int n = 0; n < NUM_MODULES; n++) begin
                cpm_r[n] <= RESET_VAL;
                cmp_r[n] <= 16'h0000;
            end
        end else if (sfr_wr_en & page_f) begin
            for (int n = 0; n < NUM_MODULES; n++) begin
                if (cpm_hit(sfr_addr, n)) begin
                    cpm_r[n] <= sfr_wdata;
                end
                // Low then high leaves compare enabled
                if (mod_hit(sfr_addr, ADDR_CPL_BASE, n)) begin
                    cmp_r[n][7:0]      <= sfr_wdata;
                    cpm_r[n][CPM_ECOM] <= 1'b0;
                end
                if (mod_hit(sfr_addr, ADDR_CPH_BASE, n)) begin
                    cmp_r[n][15:8]     <= sfr_wdata;
                    cpm_r[n][CPM_ECOM] <= 1'b1;
                end
            end
        end
    end

    // ========================================================
    // PWM modules
    for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
        capc_channel u_chan (
            .clk           (clk),
            .rst           (rst),
            .count         (count_r),
            .advanced      (adv_r),
            .wrapped       (wrap_r),
            .compare_value (cmp_r[g]),
            .mode          (cpm_r[g]),
            .pin_r         (module_output_pin[g]),
            .match         (match[g])
        );
    end

    // ========================================================
    // Interrupt request, shared by overflow and module flags
    logic irq_nxt;
    always_comb begin
        irq_nxt = ovf_r & mode_r[MODE_OVF_IE];
        for (int n = 0; n < NUM_MODULES; n++) begin
            // Software paces duty updates on this
            irq_nxt = irq_nxt | (ccf_r[n] & cpm_r[n][CPM_ECCF]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ========================================================
    // Read port, registered one cycle after the address
    always_comb begin
        ctrl_view = RESET_VAL;
        ctrl_view[CTRL_OVF] = ovf_r;
        ctrl_view[CTRL_RUN] = run_r;
        for (int n = 0; n < NUM_MODULES; n++) begin
            ctrl_view[n] = ccf_r[n];
        end
    end

    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = RESET_VAL;
        if (sfr_addr == ADDR_CTRL) begin
            rd_nxt = ctrl_view & CTRL_MASK;
        end else if (page_f) begin
            if (sfr_addr == ADDR_MODE) begin
                rd_nxt = mode_r & MODE_MASK;
            end
            for (int n = 0; n < NUM_MODULES; n++) begin
                if (cpm_hit(sfr_addr, n)) begin
                    rd_nxt = cpm_r[n];
                end
                if (mod_hit(sfr_addr, ADDR_CPL_BASE, n)) begin
                    rd_nxt = cmp_r[n][7:0];
                end
                if (mod_hit(sfr_addr, ADDR_CPH_BASE, n)) begin
                    rd_nxt = cmp_r[n][15:8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sfr_rdata_r <= RESET_VAL;
        end else begin
            sfr_rdata_r <= rd_nxt;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wrap_step;
        tick && run_en && count_r == CNT_MAX;
    endsequence

    sequence s_zero_then_wrap;
        ##1 (count_r == 16'h0000 && wrap_r);
    endsequence

    a_wrap_sets_flag: assert property (
        s_wrap_step |-> s_zero_then_wrap ##0 ovf_r)
        else $error("overflow flag not set on wrap");

    a_flag_held_hw: assert property (
        ovf_r && !wr_ctrl && !bit_wr_en |=> ovf_r)
        else $error("overflow flag cleared by hardware");

    a_count_halts: assert property (
        !run_r |=> count_r == $past(count_r))
        else $error("counter moved while stopped");

    a_idle_stops: assert property (
        mode_r[MODE_IDLE] && cpu_idle |=> $stable(count_r))
        else $error("counter moved during idle");

    a_count_step: assert property (
        tick && run_en |=> count_r == 16'($past(count_r) + CNT_ONE))
        else $error("counter step wrong");

    a_sysclk_runs: assert property (
        run_en && tb_sel == TB_SYSCLK |-> tick)
        else $error("system clock timebase missed a tick");

    a_div12_rate: assert property (
        tb_sel == TB_DIV12 && tick |=> !tick [*8])
        else $error("divide by twelve ticks too often");

    a_reserved_idle: assert property (
        tb_sel[2:1] == 2'b11 |-> !tick)
        else $error("reserved timebase ticked");

    a_eci_edge: assert property (
        tb_sel == TB_EXTIN && tick |-> ext_fall)
        else $error("external tick without falling edge");

    a_irq_overflow: assert property (
        ovf_r && mode_r[MODE_OVF_IE] |=> irq_r)
        else $error("overflow interrupt missing");

    a_low_clears_en: assert property (
        sfr_wr_en && page_f && sfr_addr == ADDR_CPL_BASE
        |=> !cpm_r[0][CPM_ECOM])
        else $error("low byte write left compare enabled");

    a_high_sets_en: assert property (
        sfr_wr_en && page_f && sfr_addr == ADDR_CPH_BASE
        |=> cpm_r[0][CPM_ECOM])
        else $error("high byte write left compare disabled");

    a_match_flag: assert property (
        match[0] && cpm_r[0][CPM_MAT] |=> ccf_r[0])
        else $error("match did not set event flag");

    a_pin_rises: assert property (
        match[0] && cpm_r[0][CPM_PWM] && cpm_r[0][CPM_WIDE]
        |=> module_output_pin[0])
        else $error("pin not high after match");

    a_unused_zero: assert property (
        ##1 $past(sfr_addr) == ADDR_CTRL |-> sfr_rdata_r[5:3] == 3'h0)
        else $error("unused control bits read nonzero");
endmodule
`default_nettype wire

// ### tb/capc_pwm_load.sv
// Load model on one PWM output pin, measuring the last high pulse
`timescale 1ns/1ns
`default_nettype none
module capc_pwm_load (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Driven pin
    input  wire logic        pin,
    // Length of the last complete high pulse, in clock cycles
    output logic      [31:0] high_len
);
    logic [31:0] run_r;

    // ========================================================
    // Pulse measurement
    always_ff @(posedge clk) begin
        if (rst || !pin) begin
            run_r <= 32'h0;
        end else begin
            run_r <= run_r + 32'h1;
        end
    end

    // Latched on the falling edge so a pulse in progress never shows
    always_ff @(posedge clk) begin
        if (rst) begin
            high_len <= 32'h0;
        end else if (!pin && run_r != 32'h0) begin
            high_len <= run_r;
        end
    end
endmodule
`default_nettype wire

// ### tb/capc_tb_top.sv
// Self-checking bench for the counter array 16-bit PWM block
`timescale 1ns/1ns
`default_nettype none
module capc_tb_top
    import capc_pkg::*;
;
    logic        clk;
    logic        rst;
    logic [7:0]  sfr_addr;
    logic [3:0]  sfr_page;
    logic        sfr_wr_en;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata_r;
    logic        bit_wr_en;
    logic [2:0]  bit_index;
    logic        bit_value;
    logic        cpu_idle;
    logic        t0_ovf;
    logic        ext_in;
    logic        osc_clk;
    logic [2:0]  tb_code;
    logic [2:0]  module_output_pin;
    logic        irq_r;
    logic [31:0] high_len;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t0;
    int          elapsed;

    // ========================================================
    // Design and load
    capc_top #(.NUM_MODULES(3)) DUT (
        .clk                  (clk),
        .rst                  (rst),
        .sfr_addr             (sfr_addr),
        .sfr_page             (sfr_page),
        .sfr_wr_en            (sfr_wr_en),
        .sfr_wdata            (sfr_wdata),
        .sfr_rdata_r          (sfr_rdata_r),
        .bit_wr_en            (bit_wr_en),
        .bit_index            (bit_index),
        .bit_value            (bit_value),
        .cpu_idle             (cpu_idle),
        .timer0_overflow      (t0_ovf),
        .external_count_input (ext_in),
        .external_osc_clk     (osc_clk),
        .module_output_pin    (module_output_pin),
        .irq_r                (irq_r)
    );

    capc_pwm_load LOAD (
        .clk      (clk),
        .rst      (rst),
        .pin      (module_output_pin[0]),
        .high_len (high_len)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    // ========================================================
    // Access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] p,
                      input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_page = p;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(negedge clk);
        sfr_wr_en = 1'b0;
    endtask

    // Read data lags the address by one cycle
    task automatic rchk(input logic [7:0] a, input logic [3:0] p,
                        input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        sfr_page = p;
        @(negedge clk);
        @(negedge clk);
        chk(sfr_rdata_r, exp);
    endtask

    task automatic bw(input logic [2:0] idx, input logic v);
        @(negedge clk);
        bit_index = idx;
        bit_value = v;
        bit_wr_en = 1'b1;
        @(negedge clk);
        bit_wr_en = 1'b0;
    endtask

    task automatic idle_for(input int n);
        cpu_idle = 1'b1;
        repeat (n) @(negedge clk);
        cpu_idle = 1'b0;
    endtask

    task automatic wait_pin(input int n, input logic lvl, input int lim);
        int k;
        k = 0;
        while (module_output_pin[n] !== lvl && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (k >= lim) begin
            n_errors++;
            $display("ERROR t=%0t pin %0d wait timed out", $time, n);
        end
    endtask

    // Source 0 timer pulses, 1 input falls, 2 eight oscillator rises each
    task automatic pulse_src(input int s, input int n);
        repeat (s == 2 ? 8 * n : n) begin
            @(negedge clk);
            if (s == 0) t0_ovf = 1'b1;
            if (s == 1) ext_in = 1'b0;
            if (s == 2) osc_clk = 1'b1;
            @(negedge clk);
            t0_ovf = 1'b0;
            repeat (s == 1 ? 3 : 1) @(negedge clk);
            ext_in = 1'b1;
            osc_clk = 1'b0;
            repeat (s == 1 ? 3 : 1) @(negedge clk);
        end
    endtask

    function automatic logic [7:0] cpm(input int n);
        return ADDR_CPM_BASE + 8'(n);
    endfunction

    function automatic logic [7:0] cpl(input int n);
        return ADDR_CPL_BASE + ADDR_CP_STEP * 8'(n);
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ========================================================
    // Watchdog, sized above one full 65536-cycle period
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        tally_and_finish;
    end

    // ========================================================
    // Tests
    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_page = 4'h0;
        sfr_wr_en = 1'b0;
        sfr_wdata = 8'h00;
        bit_wr_en = 1'b0;
        bit_index = 3'h0;
        bit_value = 1'b0;
        cpu_idle = 1'b0;
        t0_ovf = 1'b0;
        ext_in = 1'b1;
        osc_clk = 1'b0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rchk(ADDR_CTRL, 4'h0, 8'h00);
        rchk(ADDR_MODE, PAGE_F, 8'h00);
        wr(ADDR_MODE, PAGE_F, 8'hFF);
        rchk(ADDR_MODE, PAGE_F, 8'h8F);
        rchk(ADDR_MODE, 4'h0, 8'h00);
        rchk(8'hA1, PAGE_F, 8'h00);
        // Reserved timebase left selected so the counter stays put
        wr(ADDR_CTRL, 4'h3, 8'hBF);
        rchk(ADDR_CTRL, 4'h5, 8'h87);
        wr(ADDR_CTRL, 4'h0, 8'h00);
        bw(3'h6, 1'b1);
        bw(3'h4, 1'b1);
        rchk(ADDR_CTRL, 4'h9, 8'h40);
        bw(3'h6, 1'b0);
        rchk(ADDR_CTRL, 4'h2, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_MODE, PAGE_F, 8'(c << 1));
            rchk(ADDR_MODE, PAGE_F, 8'(c << 1));
        end
        $display("test registers done");

        wr(cpm(0), PAGE_F, 8'hCB);
        wr(cpl(0), PAGE_F, 8'hF0);
        rchk(cpm(0), PAGE_F, 8'h8B);
        wr(cpl(0) + 8'h01, PAGE_F, 8'hFF);
        rchk(cpm(0), PAGE_F, 8'hCB);
        wr(cpm(1), PAGE_F, 8'h82);
        wr(cpl(1), PAGE_F, 8'h00);
        wr(cpl(1) + 8'h01, PAGE_F, 8'h00);
        rchk(cpm(1), PAGE_F, 8'hC2);
        wr(cpm(2), PAGE_F, 8'hCA);
        wr(cpl(2), PAGE_F, 8'h10);
        rchk(cpm(2), PAGE_F, 8'h8A);
        $display("test compare setup done");

        // System clock timebase with overflow interrupt enabled
        wr(ADDR_MODE, PAGE_F, 8'h09);
        bw(3'h6, 1'b1);
        t0 = cyc;
        idle_for(30);
        repeat (100) @(negedge clk);
        bw(3'h6, 1'b0);
        repeat (50) @(negedge clk);
        bw(3'h6, 1'b1);
        wr(ADDR_MODE, PAGE_F, 8'h89);
        idle_for(100);
        rchk(ADDR_CTRL, 4'h0, 8'h40);
        chk({7'h0, irq_r}, 8'h00);
        wait_pin(0, 1'b1, 70000);
        elapsed = cyc - t0;
        chk({7'h0, elapsed >= 65668 && elapsed <= 65685}, 8'h01);
        repeat (3) @(negedge clk);
        rchk(ADDR_CTRL, 4'h0, 8'h41);
        chk({7'h0, irq_r}, 8'h01);
        wait_pin(0, 1'b0, 40);
        repeat (2) @(negedge clk);
        chk(high_len[7:0], 8'h10);
        rchk(ADDR_CTRL, 4'h0, 8'hC1);
        chk({5'h0, module_output_pin}, 8'h02);
        $display("test pwm period done");

        bw(3'h0, 1'b0);
        repeat (3) @(negedge clk);
        chk({7'h0, irq_r}, 8'h01);
        wr(ADDR_MODE, PAGE_F, 8'h88);
        repeat (3) @(negedge clk);
        chk({7'h0, irq_r}, 8'h00);
        rchk(ADDR_CTRL, 4'h0, 8'hC0);
        bw(3'h7, 1'b0);
        rchk(ADDR_CTRL, 4'h0, 8'h40);
        $display("test flags done");

        // Each slow source from a fresh reset, compare of three
        for (int s = 0; s < 3; s++) begin
            rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
            chk({5'h0, module_output_pin}, 8'h00);
            tb_code = (s == 2) ? TB_EXTOSC : 3'(TB_TIMER0 + 3'(s));
            wr(ADDR_MODE, PAGE_F, {4'h0, tb_code, 1'b0});
            wr(cpm(2), PAGE_F, 8'h48);
            wr(cpl(2), PAGE_F, 8'h03);
            wr(cpl(2) + 8'h01, PAGE_F, 8'h00);
            bw(3'h6, 1'b1);
            pulse_src(s, 2);
            repeat (8) @(negedge clk);
            rchk(ADDR_CTRL, 4'h0, 8'h40);
            pulse_src(s, 1);
            repeat (8) @(negedge clk);
            rchk(ADDR_CTRL, 4'h0, 8'h44);
            $display("test source %0d done", s);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
